// ==== verilog/occ_regs.vh ====
/*
 header of constants for the output compare channel control block.
 assumes inclusion by bare name from the design files.
*/
`ifndef OCC_REGS_VH
`define OCC_REGS_VH

// register word addresses on the plain register port
`define OCC_ADDR_CTRL 4'h0
`define OCC_ADDR_CMP_A 4'h1
`define OCC_ADDR_CMP_B 4'h2
`define OCC_ADDR_IRQ_STAT 4'h3
`define OCC_ADDR_IRQ_MASK 4'h4

// control register field positions
`define OCC_BIT_IDLE_STOP 13
`define OCC_BIT_FAULT_FLAG 4
`define OCC_BIT_TB_SEL 3
`define OCC_MODE_MSB 2
`define OCC_MODE_LSB 0
`define OCC_CTRL_RESET 16'h0000
`define OCC_CTRL_WMASK 16'h200f

// compare mode codes
`define OCC_MODE_OFF 3'h0
`define OCC_MODE_ONE_HIGH 3'h1
`define OCC_MODE_ONE_LOW 3'h2
`define OCC_MODE_TOGGLE 3'h3
`define OCC_MODE_SINGLE 3'h4
`define OCC_MODE_CONT 3'h5
`define OCC_MODE_PWM 3'h6
`define OCC_MODE_PWM_FLT 3'h7

// interrupt status bits
`define OCC_IRQ_MATCH 0
`define OCC_IRQ_FAULT 1
`define OCC_IRQ_W 2

`endif

// ==== verilog/occ_edge_detect.v ====
/*
 falling edge detector for the fault input.
 assumes the input is synchronous to the clock.
*/
`timescale 1ns/1ns
module occ_edge_detect (
    // clock and reset
    input wire core_clk_i,
    input wire arst_n_i,
    // level in, pulse out
    input wire level_i,
    output wire fall_o
);
    reg prev;

    // remember last level, idle high
    always @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            prev <= 1'b1;
        end else begin
            prev <= level_i;
        end
    end

    assign fall_o = prev & ~level_i;
endmodule

// ==== verilog/occ_irq.v ====
/*
 sticky interrupt status with write-one-to-clear and mask.
 assumes event pulses and bus strobes are synchronous to the clock.
*/
`timescale 1ns/1ns
module occ_irq #(
    parameter W = 2
) (
    // clock and reset
    input wire core_clk_i,
    input wire arst_n_i,
    // events and software access
    input wire [W-1:0] event_i,
    input wire clear_we_i,
    input wire mask_we_i,
    input wire [W-1:0] wdata_i,
    // state
    output reg [W-1:0] status_o,
    output reg [W-1:0] mask_o,
    output reg irq_o
);
    wire [W-1:0] next_status;

    // set wins over a same-cycle clear
    assign next_status = (status_o & ~(clear_we_i ? wdata_i : {W{1'b0}}))
        | event_i;

    // status, mask and registered interrupt level
    always @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            status_o <= {W{1'b0}};
            mask_o <= {W{1'b0}};
            irq_o <= 1'b0;
        end else begin
            status_o <= next_status;
            if (mask_we_i) begin
                mask_o <= wdata_i;
            end
            irq_o <= |(next_status & (mask_we_i ? wdata_i : mask_o));
        end
    end
endmodule

// ==== verilog/occ_channel.v ====
/*
 output compare channel: control register, mode logic, pin drive.
 assumes two 16-bit timer counts, fault input and register strobes are
 synchronous to core_clk_i; read data appear one cycle after the strobe.
*/
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/1ns
`include "occ_regs.vh"

// Operation
// - idle-stop bit freezes channel during idle
// - fault flag read-only, cleared by any control write; a fault edge in mode 111 in the same cycle sets it instead
// - fault flag set only in mode 111
// - timebase select: 1 second, 0 first
// - codes 110/111 run pwm, fault ignored/enabled
// - code 101 low then continuous pulses
// - code 100 low then exactly one pulse
// - code 011 toggles pin on match
// - code 010 init high, match forces low
// - code 001 init low, match forces high
// - code 000 disabled, pin not driven
// - pin changes when timer equals compare value
// - fault falling edge in mode 111 raises channel interrupt
module occ_channel #(
    parameter TW = 16
) (
    // clock and reset
    input wire core_clk_i,
    input wire arst_n_i,
    // register port
    input wire [3:0] addr_i,
    input wire [15:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [15:0] rdata_o,
    // time bases and system state
    input wire [TW-1:0] timebase_first_i,
    input wire [TW-1:0] timebase_second_i,
    input wire cpu_idle_i,
    input wire fault_input_a_i,
    // pin and interrupt
    output reg compare_output_pin_o,
    output reg compare_output_pin_oe_o,
    output wire irq_o
);
    // one-hot pulse states for modes 100 and 101; mode 100 parks in
    // ST_DONE until the next control write re-arms it
    localparam ST_WAIT_A = 3'b001;
    localparam ST_WAIT_B = 3'b010;
    localparam ST_DONE = 3'b100;

    // control fields, compare values and the pulse sequencer
    reg idle_stop_bit;
    reg pwm_fault_flag;
    reg timebase_select;
    reg [2:0] compare_mode_field;
    reg [TW-1:0] cmp_a;
    reg [TW-1:0] cmp_b;
    reg [2:0] state;
    reg [2:0] next_state;
    reg next_pin;
    reg init_pending;
    reg match_evt;
    // compare path, strobes and interrupt plumbing
    wire [TW-1:0] count;
    wire run;
    wire hit_a;
    wire hit_b;
    wire fault_fall;
    wire ctrl_we;
    wire [`OCC_IRQ_W-1:0] irq_event;
    wire [`OCC_IRQ_W-1:0] irq_status;
    wire [`OCC_IRQ_W-1:0] irq_mask;
    wire irq_level;

    // decode a write enable at a given address
    function wr_hit;
        input [3:0] a;
        input [3:0] target;
        input w;
        begin
            wr_hit = w & (a == target);
        end
    endfunction

    // mode 111 is the only code that watches the fault input
    function fault_mode;
        input [2:0] m;
        begin
            fault_mode = (m == `OCC_MODE_PWM_FLT);
        end
    endfunction

    // pwm level at the period start: high only for a nonzero duty
    function pwm_start;
        input [TW-1:0] duty;
        begin
            pwm_start = (duty != {TW{1'b0}});
        end
    endfunction

    // compared count, and match strobes held off in idle stop; a timer
    // left running across a control write may match on the old mode,
    // which is why software stops it first
    assign count = timebase_select ? timebase_second_i
        : timebase_first_i;
    assign run = ~(idle_stop_bit & cpu_idle_i);
    assign hit_a = run & (count == cmp_a);
    assign hit_b = run & (count == cmp_b);
    assign ctrl_we = wr_hit(addr_i, `OCC_ADDR_CTRL, wr_i);

    // fault edge detector; it idles high, so reset raises no false
    // edge and a fault held low needs a fresh fall to count again
    occ_edge_detect u_fault_edge (
        .core_clk_i(core_clk_i),
        .arst_n_i(arst_n_i),
        .level_i(fault_input_a_i),
        .fall_o(fault_fall)
    );

    // control and compare registers; fault flag is hardware owned, so
    // bit 4 of a written control word is dropped
    always @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            idle_stop_bit <= 1'b0;
            timebase_select <= 1'b0;
            compare_mode_field <= `OCC_MODE_OFF;
            cmp_a <= {TW{1'b0}};
            cmp_b <= {TW{1'b0}};
            init_pending <= 1'b0;
        end else begin
            init_pending <= ctrl_we;
            if (ctrl_we) begin
                idle_stop_bit <= wdata_i[`OCC_BIT_IDLE_STOP];
                timebase_select <= wdata_i[`OCC_BIT_TB_SEL];
                compare_mode_field <=
                    wdata_i[`OCC_MODE_MSB:`OCC_MODE_LSB];
            end
            if (wr_hit(addr_i, `OCC_ADDR_CMP_A, wr_i)) begin
                cmp_a <= wdata_i[TW-1:0];
            end
            if (wr_hit(addr_i, `OCC_ADDR_CMP_B, wr_i)) begin
                cmp_b <= wdata_i[TW-1:0];
            end
        end
    end

    // fault flag: set in mode 111 on fault, cleared on mode rewrite;
    // a fault edge that falls while frozen is lost, the detector runs on
    always @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pwm_fault_flag <= 1'b0;
        end else if (fault_mode(compare_mode_field)
                     && run && fault_fall) begin
            pwm_fault_flag <= 1'b1;
        end else if (ctrl_we) begin
            pwm_fault_flag <= 1'b0;
        end
    end

    // next pin level and pulse state per mode
    always @* begin
        next_pin = compare_output_pin_o;
        next_state = state;
        match_evt = 1'b0;
        // a control write re-arms the mode even when frozen, since the
        // cpu cannot write while it is idle
        if (init_pending) begin
            next_state = ST_WAIT_A;
            case (compare_mode_field)
                `OCC_MODE_ONE_LOW: next_pin = 1'b1;
                `OCC_MODE_TOGGLE: next_pin = compare_output_pin_o;
                `OCC_MODE_PWM, `OCC_MODE_PWM_FLT:
                    next_pin = pwm_start(cmp_a);
                default: next_pin = 1'b0;
            endcase
        end else if (run) begin
            // one-shot events fire only on a real change; a match on a
            // pin already at its target raises nothing
            case (compare_mode_field)
                `OCC_MODE_ONE_HIGH: begin
                    if (hit_a && !compare_output_pin_o) begin
                        next_pin = 1'b1;
                        match_evt = 1'b1;
                    end
                end
                `OCC_MODE_ONE_LOW: begin
                    if (hit_a && compare_output_pin_o) begin
                        next_pin = 1'b0;
                        match_evt = 1'b1;
                    end
                end
                `OCC_MODE_TOGGLE: begin
                    if (hit_a) begin
                        next_pin = ~compare_output_pin_o;
                        match_evt = 1'b1;
                    end
                end
                `OCC_MODE_SINGLE, `OCC_MODE_CONT: begin
                    case (state)
                        ST_WAIT_A: begin
                            if (hit_a) begin
                                next_pin = 1'b1;
                                next_state = ST_WAIT_B;
                            end
                        end
                        ST_WAIT_B: begin
                            if (hit_b) begin
                                next_pin = 1'b0;
                                match_evt = 1'b1;
                                if (compare_mode_field == `OCC_MODE_CONT) begin
                                    next_state = ST_WAIT_A;
                                end else begin
                                    next_state = ST_DONE;
                                end
                            end
                        end
                        ST_DONE: next_pin = 1'b0;
                        default: next_state = ST_WAIT_A;
                    endcase
                end
                `OCC_MODE_PWM, `OCC_MODE_PWM_FLT: begin
                    // fault first, so a period start cannot lift the pin
                    if (fault_mode(compare_mode_field)
                        && (pwm_fault_flag || fault_fall)) begin
                        next_pin = 1'b0;
                    end else if (count == {TW{1'b0}}) begin
                        next_pin = pwm_start(cmp_a);
                    end else if (hit_a) begin
                        next_pin = 1'b0;
                    end
                end
                default: next_pin = 1'b0;
            endcase
        end
    end

    // pin, enable and pulse state flip-flops; the enable drops with
    // mode 000 so the pad falls back to its pull
    always @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            compare_output_pin_o <= 1'b0;
            compare_output_pin_oe_o <= 1'b0;
            state <= ST_WAIT_A;
        end else begin
            compare_output_pin_o <= next_pin;
            compare_output_pin_oe_o <=
                (compare_mode_field != `OCC_MODE_OFF);
            state <= next_state;
        end
    end

    // interrupt events: match strobe from the pin logic, fault edge
    // only in mode 111; the pwm codes raise no match event
    assign irq_event[`OCC_IRQ_MATCH] = match_evt;
    assign irq_event[`OCC_IRQ_FAULT] = run & fault_fall
        & fault_mode(compare_mode_field);

    // sticky status and mask; the level is registered inside, so the
    // interrupt output needs no flop of its own here
    occ_irq #(
        .W(`OCC_IRQ_W)
    ) u_irq (
        .core_clk_i(core_clk_i),
        .arst_n_i(arst_n_i),
        .event_i(irq_event),
        .clear_we_i(wr_hit(addr_i, `OCC_ADDR_IRQ_STAT, wr_i)),
        .mask_we_i(wr_hit(addr_i, `OCC_ADDR_IRQ_MASK, wr_i)),
        .wdata_i(wdata_i[`OCC_IRQ_W-1:0]),
        .status_o(irq_status),
        .mask_o(irq_mask),
        .irq_o(irq_level)
    );
    assign irq_o = irq_level;

    // read data, one cycle after the strobe, zero otherwise; unmapped
    // words read zero as well
    always @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_o <= 16'h0000;
        end else if (rd_i) begin
            case (addr_i)
                `OCC_ADDR_CTRL: begin
                    rdata_o <= 16'h0000;
                    rdata_o[`OCC_BIT_IDLE_STOP] <= idle_stop_bit;
                    rdata_o[`OCC_BIT_FAULT_FLAG] <= pwm_fault_flag;
                    rdata_o[`OCC_BIT_TB_SEL] <= timebase_select;
                    rdata_o[`OCC_MODE_MSB:`OCC_MODE_LSB] <=
                        compare_mode_field;
                end
                `OCC_ADDR_CMP_A: rdata_o <= cmp_a;
                `OCC_ADDR_CMP_B: rdata_o <= cmp_b;
                `OCC_ADDR_IRQ_STAT: rdata_o <= {14'h0000, irq_status};
                `OCC_ADDR_IRQ_MASK: rdata_o <= {14'h0000, irq_mask};
                default: rdata_o <= 16'h0000;
            endcase
        end else begin
            rdata_o <= 16'h0000;
        end
    end
endmodule

// ==== tb/occ_channel_chk.sv ====
/*
 checker of occ_channel, bound to it at the foot of this file.
 assumes the channel's register map and pin timing.
*/
`timescale 1ns/1ns
module occ_channel_chk #(
    parameter TW = 16
) (
    // clock, reset, register port
    input wire core_clk_i,
    input wire arst_n_i,
    input wire [3:0] addr_i,
    input wire [15:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    input wire [15:0] rdata_o,
    // time bases, system, pin
    input wire [TW-1:0] timebase_first_i,
    input wire [TW-1:0] timebase_second_i,
    input wire cpu_idle_i,
    input wire fault_input_a_i,
    input wire compare_output_pin_o,
    input wire compare_output_pin_oe_o,
    input wire irq_o
);
    reg [2:0] m;
    reg [1:0] age;
    reg stop;
    reg tsel;
    reg fmask;
    reg [TW-1:0] cmp;
    wire cw = wr_i && addr_i == 4'h0;
    wire frz = stop && cpu_idle_i;
    wire on = age[1] && !frz;
    wire mt = on && (tsel ? timebase_second_i : timebase_first_i) == cmp;
    wire pin = compare_output_pin_o;
    // shadow of control, compare a and fault mask; age since control write
    always @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            m <= 3'h0;
            age <= 2'h0;
            stop <= 1'b0;
            tsel <= 1'b0;
            fmask <= 1'b0;
            cmp <= {TW{1'b0}};
        end else begin
            if (cw) begin
                m <= wdata_i[2:0];
                tsel <= wdata_i[3];
                stop <= wdata_i[13];
            end
            age <= cw ? 2'h0 : age + {1'b0, age != 2'h3};
            if (wr_i && addr_i == 4'h1)
                cmp <= wdata_i[TW-1:0];
            if (wr_i && addr_i == 4'h4)
                fmask <= wdata_i[1];
        end
    end
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!arst_n_i);
    property p_drive;
        $stable(m) |-> compare_output_pin_oe_o == (m != 3'h0);
    endproperty
    a_drive: assert property (p_drive) else $error("pin drive");
    property p_init;
        (m == 3'h1 || m == 3'h2) && age == 2'h1 |-> pin == m[1];
    endproperty
    a_init: assert property (p_init) else $error("init");
    property p_set;
        m == 3'h1 && mt |=> pin;
    endproperty
    a_set: assert property (p_set) else $error("set on match");
    property p_clr;
        m == 3'h2 && mt |=> !pin;
    endproperty
    a_clr: assert property (p_clr) else $error("clear on match");
    property p_tog;
        m == 3'h3 && mt |=> pin != $past(pin);
    endproperty
    a_tog: assert property (p_tog) else $error("toggle");
    property p_pwm;
        m[2:1] == 2'b11 && mt |=> !pin;
    endproperty
    a_pwm: assert property (p_pwm) else $error("pwm match");
    property p_frz;
        frz |=> $stable(pin);
    endproperty
    a_frz: assert property (p_frz) else $error("idle freeze");
    property p_fpin;
        on && m == 3'h7 && $fell(fault_input_a_i) |-> ##3 !pin [*4];
    endproperty
    a_fpin: assert property (p_fpin) else $error("fault pin");
    property p_firq;
        on && m == 3'h7 && fmask && $fell(fault_input_a_i)
            |-> ##[1:5] irq_o;
    endproperty
    a_firq: assert property (p_firq) else $error("fault irq");
    c_fault: cover property (on && m == 3'h7 && $fell(fault_input_a_i));
    c_frz: cover property (frz && m == 3'h3);
    c_pulse: cover property (m == 3'h5 && mt);
endmodule

bind occ_channel occ_channel_chk #(.TW(TW)) u_chk (
    .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .timebase_first_i(timebase_first_i),
    .timebase_second_i(timebase_second_i), .cpu_idle_i(cpu_idle_i),
    .fault_input_a_i(fault_input_a_i),
    .compare_output_pin_o(compare_output_pin_o),
    .compare_output_pin_oe_o(compare_output_pin_oe_o), .irq_o(irq_o)
);

// ==== tb/occ_timebase_model.sv ====
/*
 two timer time bases and the pin load beside the channel.
 assumes one clock shared with the channel.
*/
`timescale 1ns/1ns
module occ_timebase_model #(
    parameter TW = 16,
    parameter PER = 20
) (
    // clock, reset, run control
    input wire core_clk_i,
    input wire arst_n_i,
    input wire [1:0] run_i,
    // pin at the load
    input wire pin_i,
    input wire pin_oe_i,
    // counts and pin level
    output reg [TW-1:0] first_o,
    output reg [TW-1:0] second_o,
    output wire level_o
);
    // pull-down load: an undriven pin reads low
    assign level_o = pin_oe_i ? pin_i : 1'b0;
    // stopped timers are cleared so control writes meet no match
    always @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            first_o <= {TW{1'b0}};
            second_o <= {TW{1'b0}};
        end else begin
            first_o <= run_i[0] ? first_o + 1'b1 : {TW{1'b0}};
            second_o <= run_i[1] ? second_o + 1'b1 : {TW{1'b0}};
            if (first_o == PER - 1)
                first_o <= {TW{1'b0}};
            if (second_o == PER - 1)
                second_o <= {TW{1'b0}};
        end
    end
endmodule

// ==== tb/occ_channel_bench.sv ====
/*
 self-checking bench of occ_channel with the time base model.
 assumes the channel's register map and pin timing.
*/
`timescale 1ns/1ns
module occ_channel_bench;
    localparam PER = 20;
    reg clk = 1'b0;
    reg arst_n = 1'b0;
    reg [3:0] addr = 4'h0;
    reg [15:0] wdata = 16'h0;
    reg wr = 1'b0;
    reg rd = 1'b0;
    reg idle = 1'b0;
    reg fault = 1'b1;
    reg [1:0] run = 2'b00;
    wire [15:0] rdata;
    wire [15:0] tb1;
    wire [15:0] tb2;
    wire pin_q;
    wire pin_oe;
    wire irq;
    wire pin;
    integer error_cnt = 0;
    integer n_tests = 0;
    integer i;
    // clock of 25 MHz
    always #20 clk = ~clk;
    occ_channel dut (
        .core_clk_i(clk), .arst_n_i(arst_n), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
        .timebase_first_i(tb1), .timebase_second_i(tb2),
        .cpu_idle_i(idle), .fault_input_a_i(fault),
        .compare_output_pin_o(pin_q), .compare_output_pin_oe_o(pin_oe),
        .irq_o(irq)
    );
    occ_timebase_model #(.PER(PER)) tbm (
        .core_clk_i(clk), .arst_n_i(arst_n), .run_i(run),
        .pin_i(pin_q), .pin_oe_i(pin_oe), .first_o(tb1), .second_o(tb2),
        .level_o(pin)
    );
    task check(input [63:0] nm, input [15:0] seen, input [15:0] exp);
        begin
            n_tests = n_tests + 1;
            if (seen !== exp) begin
                error_cnt = error_cnt + 1;
                $display("ERROR %0s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task tick(input integer n);
        repeat (n) @(posedge clk);
    endtask
    task wr_reg(input [3:0] a, input [15:0] d);
        begin
            @(posedge clk);
            addr <= a;
            wdata <= d;
            wr <= 1'b1;
            @(posedge clk);
            wr <= 1'b0;
        end
    endtask
    task rd_reg(input [3:0] a, input [15:0] exp);
        begin
            @(posedge clk);
            addr <= a;
            rd <= 1'b1;
            @(posedge clk);
            rd <= 1'b0;
            @(negedge clk);
            check("rdata", rdata, exp);
        end
    endtask
    task go(input [1:0] r);
        begin
            @(posedge clk);
            run <= r;
        end
    endtask
    task setup(input [15:0] c, input [15:0] a, input [15:0] b);
        begin
            go(2'b00);
            wr_reg(4'h1, a);
            wr_reg(4'h2, b);
            wr_reg(4'h0, c);
            tick(3);
        end
    endtask
    task look(input integer n, input sel, input v);
        begin
            tick(n);
            @(negedge clk);
            if (sel)
                check("irq", {15'h0, irq}, {15'h0, v});
            else
                check("pin", {15'h0, pin}, {15'h0, v});
        end
    endtask
    task pin_is(input v);
        integer k;
        begin
            k = 0;
            @(negedge clk);
            while (pin !== v && k < 3 * PER) begin
                @(negedge clk);
                k = k + 1;
            end
            check("pin", {15'h0, pin}, {15'h0, v});
        end
    endtask
    task done(input [63:0] nm);
        $display("test %0s done", nm);
    endtask
    task close_out;
        begin
            $display("checks %0d mismatches %0d", n_tests, error_cnt);
            if (error_cnt == 0 && n_tests > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    // watchdog far beyond the expected run
    initial begin
        #400000;
        error_cnt = error_cnt + 1;
        close_out;
    end
    // main sequence
    initial begin
        tick(2);
        arst_n <= 1'b1;
        rd_reg(4'h0, 16'h0000);
        look(0, 1'b0, 1'b0);
        wr_reg(4'h0, 16'hffff);
        rd_reg(4'h0, 16'h200f);
        wr_reg(4'h9, 16'hffff);
        rd_reg(4'h9, 16'h0000);
        done("regs");
        wr_reg(4'h4, 16'h0001);
        setup(16'h0001, 16'h0005, 16'h0000);
        look(0, 1'b0, 1'b0);
        go(2'b11);
        pin_is(1'b1);
        look(2, 1'b1, 1'b1);
        go(2'b00);
        wr_reg(4'h4, 16'h0000);
        look(1, 1'b1, 1'b0);
        wr_reg(4'h4, 16'h0001);
        look(1, 1'b1, 1'b1);
        wr_reg(4'h3, 16'h0001);
        rd_reg(4'h3, 16'h0000);
        look(0, 1'b1, 1'b0);
        setup(16'h0002, 16'h0005, 16'h0000);
        look(0, 1'b0, 1'b1);
        go(2'b11);
        pin_is(1'b0);
        setup(16'h0003, 16'h0005, 16'h0000);
        go(2'b11);
        pin_is(1'b1);
        pin_is(1'b0);
        done("shots");
        for (i = 4; i < 6; i = i + 1) begin
            setup(i[15:0], 16'h0003, 16'h0008);
            go(2'b11);
            pin_is(1'b1);
            pin_is(1'b0);
            if (i == 4)
                look(2 * PER, 1'b0, 1'b0);
            else
                pin_is(1'b1);
        end
        setup(16'h0009, 16'h0005, 16'h0000);
        go(2'b01);
        look(2 * PER, 1'b0, 1'b0);
        go(2'b10);
        pin_is(1'b1);
        setup(16'h2003, 16'h0005, 16'h0000);
        @(posedge clk);
        idle <= 1'b1;
        go(2'b11);
        look(2 * PER, 1'b0, 1'b1);
        @(posedge clk);
        idle <= 1'b0;
        pin_is(1'b0);
        done("pulses");
        wr_reg(4'h4, 16'h0002);
        for (i = 6; i < 8; i = i + 1) begin
            setup(i[15:0], 16'h0005, 16'h0000);
            go(2'b11);
            pin_is(1'b0);
            pin_is(1'b1);
            @(posedge clk);
            fault <= 1'b0;
            look(2 * PER, 1'b1, i[0]);
            rd_reg(4'h0, {11'h0, i[0], 1'b0, i[2:0]});
            if (i == 7)
                look(0, 1'b0, 1'b0);
            else
                pin_is(1'b1);
            @(posedge clk);
            fault <= 1'b1;
        end
        setup(16'h0007, 16'h0005, 16'h0000);
        rd_reg(4'h0, 16'h0007);
        go(2'b11);
        pin_is(1'b1);
        check("oe", {15'h0, pin_oe}, 16'h0001);
        setup(16'h0000, 16'h0005, 16'h0000);
        look(0, 1'b0, 1'b0);
        check("oe", {15'h0, pin_oe}, 16'h0000);
        done("pwm");
        close_out;
    end
endmodule
